// File: hw/eec_channel.v
// External event counter channel with Avalon-MM register slave
//
// Added by the designer: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "eec_consts.vh"
module eec_channel (
  input wire mclk_in,
  input wire sys_rst_in,
  input wire clk_en_in,
  input wire [`EEC_ADDR_W-1:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output reg [31:0] avs_readdata_out,
  output reg avs_waitrequest_out,
  input wire event_input_pin_in,
  output reg channel_interrupt_out,
  output reg channel_active_status_out
);
  // Register state
  reg timer_unit_clock_enable_q;
  reg [15:0] clock_prescale_select_q;
  reg [`EEC_MODE_W-1:0] channel_mode_reg_q;
  reg [15:0] channel_reload_value_q;
  reg [15:0] channel_count_value_q;
  reg [15:0] presc_cnt_q;

  // Bus handshake helpers
  wire req;
  wire wr_go;
  wire rd_go;
  wire wr_ok;
  wire start_wr;
  wire stop_wr;
  wire unit_clear;

  // Prescaled ticks and event edges
  wire [3:0] ps_tick;
  wire op_tick;
  wire ev_rise;
  wire ev_fall;
  reg ev_valid;
  reg [31:0] rd_mux;

  // Lane merge for 16-bit registers
  function [15:0] merge16;
    input [15:0] old_v;
    input [31:0] wdata;
    input [3:0] be;
    begin
      merge16 = old_v;
      if (be[0]) begin
        merge16[7:0] = wdata[7:0];
      end
      if (be[1]) begin
        merge16[15:8] = wdata[15:8];
      end
    end
  endfunction

  // Prescaler tick mask for a 4-bit divider exponent
  function [15:0] ps_mask;
    input [3:0] expo;
    begin
      ps_mask = ~(`EEC_PS_ONES << expo);
    end
  endfunction

  // Address match on a word register
  function hit;
    input [`EEC_ADDR_W-1:0] a;
    input [`EEC_ADDR_W-1:0] ref_a;
    begin
      hit = (a == ref_a);
    end
  endfunction

  assign req = avs_read_in | avs_write_in;
  // Action happens on the edge where waitrequest is seen low
  assign wr_go = avs_write_in & ~avs_waitrequest_out;
  assign rd_go = avs_read_in & ~avs_waitrequest_out;
  // Only the enable register is writable while the unit is off
  assign wr_ok = wr_go & timer_unit_clock_enable_q;
  assign start_wr = wr_ok & hit(avs_address_in, `EEC_A_TRIG)
    & avs_byteenable_in[0] & avs_writedata_in[`EEC_B_START];
  assign stop_wr = wr_ok & hit(avs_address_in, `EEC_A_TRIG)
    & avs_byteenable_in[0] & avs_writedata_in[`EEC_B_STOP];
  assign unit_clear = ~timer_unit_clock_enable_q;

  // Four prescaled operation clocks
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_ps
      assign ps_tick[gi] = timer_unit_clock_enable_q
        & ((presc_cnt_q & ps_mask(clock_prescale_select_q[gi*4+3:gi*4]))
        == ps_mask(clock_prescale_select_q[gi*4+3:gi*4]));
    end
  endgenerate

  assign op_tick = ps_tick[channel_mode_reg_q[`EEC_F_CKSEL]];

  eec_edge_filter u_filt (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .clear_in(unit_clear),
    .tick_in(op_tick),
    .filter_en_in(channel_mode_reg_q[`EEC_B_FILT]),
    .pin_in(event_input_pin_in),
    .rise_out(ev_rise),
    .fall_out(ev_fall)
  );

  // Edge selection; the prohibited code counts nothing
  always @* begin
    case (channel_mode_reg_q[`EEC_F_EDGE])
      `EEC_EDGE_FALL: begin
        ev_valid = ev_fall;
      end
      `EEC_EDGE_RISE: begin
        ev_valid = ev_rise;
      end
      `EEC_EDGE_BOTH: begin
        ev_valid = ev_rise | ev_fall;
      end
      default: begin
        ev_valid = 1'b0;
      end
    endcase
  end

  // Read data selection
  always @* begin
    rd_mux = `EEC_RD_ZERO;
    case (avs_address_in)
      `EEC_A_CTRL: begin
        rd_mux[`EEC_B_UNIT_EN] = timer_unit_clock_enable_q;
      end
      `EEC_A_PRESC: begin
        rd_mux[15:0] = clock_prescale_select_q;
      end
      `EEC_A_MODE: begin
        rd_mux[`EEC_MODE_W-1:0] = channel_mode_reg_q;
      end
      `EEC_A_RELOAD: begin
        rd_mux[15:0] = channel_reload_value_q;
      end
      `EEC_A_COUNT: begin
        rd_mux[15:0] = channel_count_value_q;
      end
      `EEC_A_STATUS: begin
        rd_mux[0] = channel_active_status_out;
      end
      default: begin
        rd_mux = `EEC_RD_ZERO;
      end
    endcase
  end

  // Bus slave: one wait cycle, then a single-cycle acceptance
  always @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= `EEC_RD_ZERO;
    end else if (clk_en_in) begin
      if (req && avs_waitrequest_out) begin
        avs_waitrequest_out <= 1'b0;
        avs_readdata_out <= avs_read_in ? rd_mux : `EEC_RD_ZERO;
      end else begin
        avs_waitrequest_out <= 1'b1;
        if (rd_go) begin
          avs_readdata_out <= avs_readdata_out;
        end
      end
    end
  end

  // Unit enable register, always writable
  always @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      timer_unit_clock_enable_q <= 1'b0;
    end else if (clk_en_in) begin
      if (wr_go && hit(avs_address_in, `EEC_A_CTRL) && avs_byteenable_in[0]) begin
        timer_unit_clock_enable_q <= avs_writedata_in[`EEC_B_UNIT_EN];
      end
    end
  end

  // Configuration registers, wiped while the unit is off
  always @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      clock_prescale_select_q <= `EEC_RST_16;
      channel_mode_reg_q <= `EEC_RST_MODE;
      channel_reload_value_q <= `EEC_RST_16;
      presc_cnt_q <= `EEC_RST_16;
    end else if (clk_en_in) begin
      if (unit_clear) begin
        clock_prescale_select_q <= `EEC_RST_16;
        channel_mode_reg_q <= `EEC_RST_MODE;
        channel_reload_value_q <= `EEC_RST_16;
        presc_cnt_q <= `EEC_RST_16;
      end else begin
        presc_cnt_q <= presc_cnt_q + `EEC_CNT_ONE;
        if (wr_ok && hit(avs_address_in, `EEC_A_PRESC)) begin
          clock_prescale_select_q <= merge16(clock_prescale_select_q,
            avs_writedata_in, avs_byteenable_in);
        end
        // Mode is not locked while running; software keeps it still
        if (wr_ok && hit(avs_address_in, `EEC_A_MODE)) begin
          channel_mode_reg_q[7:0] <= avs_byteenable_in[0] ?
            avs_writedata_in[7:0] : channel_mode_reg_q[7:0];
          channel_mode_reg_q[`EEC_B_OUT_VAL] <= avs_byteenable_in[1] ?
            avs_writedata_in[`EEC_B_OUT_VAL] : channel_mode_reg_q[`EEC_B_OUT_VAL];
        end
        if (wr_ok && hit(avs_address_in, `EEC_A_RELOAD)) begin
          channel_reload_value_q <= merge16(channel_reload_value_q,
            avs_writedata_in, avs_byteenable_in);
        end
      end
    end
  end

  // Counter, active status and interrupt
  always @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      channel_active_status_out <= 1'b0;
      channel_count_value_q <= `EEC_RST_16;
      channel_interrupt_out <= 1'b0;
    end else if (clk_en_in) begin
      channel_interrupt_out <= 1'b0;
      if (unit_clear) begin
        channel_active_status_out <= 1'b0;
        channel_count_value_q <= `EEC_RST_16;
      end else if (stop_wr) begin
        // Stop wins over a start in the same write
        channel_active_status_out <= 1'b0;
        channel_count_value_q <= channel_count_value_q;
      end else if (start_wr) begin
        channel_active_status_out <= 1'b1;
        channel_count_value_q <= channel_reload_value_q;
      end else if (channel_active_status_out && ev_valid) begin
        if (channel_count_value_q == `EEC_CNT_ZERO) begin
          // Reload uses the latest value, so edits wait for this point
          channel_count_value_q <= channel_reload_value_q;
          channel_interrupt_out <= 1'b1;
        end else begin
          channel_count_value_q <= channel_count_value_q - `EEC_CNT_ONE;
        end
      end
    end
  end
endmodule // eec_channel
`default_nettype wire

// File: hw/eec_consts.vh
// Constants for the external event counter channel
// Behaviour
// - Unit clock enable low: unit stopped, writes to all registers but the enable register ignored.
// - Unit clock enable set: unit runs, writes accepted, channel stopped.
// - Prescale select sets the rates of four prescaled operation clocks.
// - Filter enable bit switches the event input noise filter off or on.
// - Start trigger acts on a written one and reads back zero.
// - Start sets active status, loads counter from reload, awaits edges.
// - While active, each valid event edge decrements the counter by one.
// - At zero the counter reloads from the reload value and continues.
// - Interrupt pulses when a valid event edge finds the active counter at zero.
// - Reload writable while the unit clock is enabled, counter readable anytime; overflow status unused.
// - Stop trigger clears active status and halts counting.
// - After stop the counter keeps its value.
// - Unit clock enable cleared: all unit and channel state reinitialised.
// - Events between interrupts equal reload value plus one.
// - New reload value takes effect only at the next start or reload.
// - Edge select: 00 falling, 01 rising, 10 both, 11 prohibited.
`ifndef EEC_CONSTS_VH
`define EEC_CONSTS_VH
`define EEC_ADDR_W 5
`define EEC_A_CTRL 5'h00
`define EEC_A_PRESC 5'h04
`define EEC_A_MODE 5'h08
`define EEC_A_RELOAD 5'h0C
`define EEC_A_COUNT 5'h10
`define EEC_A_TRIG 5'h14
`define EEC_A_STATUS 5'h18
`define EEC_B_UNIT_EN 0
`define EEC_B_START 0
`define EEC_B_STOP 1
`define EEC_F_CKSEL 1:0
`define EEC_F_EDGE 3:2
`define EEC_B_FILT 4
`define EEC_B_OUT_EN 5
`define EEC_B_OUT_MODE 6
`define EEC_B_OUT_LVL 7
`define EEC_B_OUT_VAL 8
`define EEC_MODE_W 9
`define EEC_EDGE_FALL 2'h0
`define EEC_EDGE_RISE 2'h1
`define EEC_EDGE_BOTH 2'h2
`define EEC_RST_MODE 9'h000
`define EEC_RST_16 16'h0000
`define EEC_CNT_ZERO 16'h0000
`define EEC_CNT_ONE 16'h0001
`define EEC_RD_ZERO 32'h00000000
`define EEC_PS_ONES 16'hFFFF
`endif

// File: hw/eec_edge_filter.v
// Event input synchroniser, noise filter and edge detector
`timescale 1ns/1ps
`default_nettype none
module eec_edge_filter (
  input wire mclk_in,
  input wire sys_rst_in,
  input wire clk_en_in,
  input wire clear_in,
  input wire tick_in,
  input wire filter_en_in,
  input wire pin_in,
  output reg rise_out,
  output reg fall_out
);
  reg sync1_q;
  reg sync2_q;
  reg smp_q;
  reg lvl_q;
  reg lvl_d;

  always @* begin
    lvl_d = lvl_q;
    if (tick_in && (!filter_en_in || sync2_q == smp_q)) begin
      lvl_d = sync2_q;
    end
  end

  // Edges are judged only on operation clock ticks
  always @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      smp_q <= 1'b0;
      lvl_q <= 1'b0;
      rise_out <= 1'b0;
      fall_out <= 1'b0;
    end else if (clk_en_in) begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      if (clear_in) begin
        smp_q <= 1'b0;
        lvl_q <= 1'b0;
        rise_out <= 1'b0;
        fall_out <= 1'b0;
      end else begin
        if (tick_in) begin
          smp_q <= sync2_q;
        end
        lvl_q <= lvl_d;
        rise_out <= lvl_d & ~lvl_q;
        fall_out <= ~lvl_d & lvl_q;
      end
    end
  end
endmodule // eec_edge_filter
`default_nettype wire

// File: bench/eec_assertions.sv
// Port checker for the event counter channel
`timescale 1ns/1ps
`default_nettype none
`include "eec_consts.vh"
module eec_checker (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic [`EEC_ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic event_input_pin_in,
  input wire logic channel_interrupt_out,
  input wire logic channel_active_status_out
);
  logic en_q;
  wire act = channel_active_status_out;
  wire irq = channel_interrupt_out;
  wire wt = avs_waitrequest_out;
  wire req = avs_read_in | avs_write_in;
  wire acc = req & ~wt & clk_en_in;
  wire wl = acc & avs_write_in & avs_byteenable_in[0];
  wire trig = wl && avs_address_in == `EEC_A_TRIG;
  wire ctrl = wl && avs_address_in == `EEC_A_CTRL;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  // Unit enable is not a port, so mirror it from bus writes
  always @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      en_q <= 1'b0;
    end else if (ctrl) begin
      en_q <= avs_writedata_in[0];
    end
  end
  property p_start; trig && avs_writedata_in[0] && !avs_writedata_in[1] |=> act == en_q; endproperty
  property p_stop; trig && avs_writedata_in[1] |=> !act; endproperty
  // The clear follows the enable register, one cycle behind the write
  property p_off; ctrl && !avs_writedata_in[0] |-> ##2 !act; endproperty
  property p_trig_rd; acc && avs_read_in && avs_address_in == `EEC_A_TRIG |-> avs_readdata_out == 32'h0; endproperty
  property p_act_chg; $changed(act) |-> $past(trig) || $past(ctrl, 2); endproperty
  property p_irq_pulse; irq |=> !irq; endproperty
  property p_irq_act; irq |-> act && $past(act); endproperty
  property p_wait; clk_en_in && req && wt |=> !wt; endproperty
  property p_wait_one; !wt |=> wt; endproperty
  property p_idle; !req |=> wt; endproperty
  a_start: assert property (p_start) else $error("start");
  a_stop: assert property (p_stop) else $error("stop");
  a_off: assert property (p_off) else $error("unit off");
  a_trig_rd: assert property (p_trig_rd) else $error("trigger read");
  a_act_chg: assert property (p_act_chg) else $error("active change");
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq width");
  a_irq_act: assert property (p_irq_act) else $error("irq idle");
  a_wait: assert property (p_wait) else $error("wait late");
  a_wait_one: assert property (p_wait_one) else $error("wait width");
  a_idle: assert property (p_idle) else $error("wait idle");
  c_irq: cover property (irq);
  c_start: cover property (trig && avs_writedata_in[0]);
  c_stop: cover property (trig && avs_writedata_in[1]);
endmodule // eec_checker
bind eec_channel eec_checker u_chk (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .event_input_pin_in(event_input_pin_in), .channel_interrupt_out(channel_interrupt_out),
  .channel_active_status_out(channel_active_status_out));
`default_nettype wire

// File: bench/eec_event_src.sv
// Event source model on the channel's event pin
`timescale 1ns/1ps
`default_nettype none
module eec_event_src (
  input wire logic clk_in,
  output logic pin_out
);
  initial pin_out = 1'b0;
  // Levels held past sync and filter depth, else edges vanish
  task automatic toggle(input int n, input int hold);
    for (int i = 0; i < n; i++) begin
      repeat (hold) @(posedge clk_in);
      pin_out <= ~pin_out;
    end
    repeat (hold) @(posedge clk_in);
  endtask
endmodule // eec_event_src
`default_nettype wire

// File: bench/tb.sv
// Register-level testbench for the event counter channel
`timescale 1ns/1ps
`default_nettype none
`include "eec_consts.vh"
module tb;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic [`EEC_ADDR_W-1:0] avs_address_in = 5'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0] avs_byteenable_in = 4'hF;
  wire logic [31:0] avs_readdata_out;
  wire logic avs_waitrequest_out;
  wire logic event_input_pin_in;
  wire logic channel_interrupt_out;
  wire logic channel_active_status_out;
  logic [31:0] q;
  logic [31:0] e;
  int n_errors = 0;
  int total_checks = 0;
  int n_irq = 0;
  always #25 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (channel_interrupt_out === 1'b1) n_irq <= n_irq + 1;
  eec_channel uut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .event_input_pin_in(event_input_pin_in), .channel_interrupt_out(channel_interrupt_out),
    .channel_active_status_out(channel_active_status_out));
  eec_event_src src (.clk_in(mclk_in), .pin_out(event_input_pin_in));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d, input logic [3:0] be);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_byteenable_in <= be;
    avs_write_in <= w;
    avs_read_in <= ~w;
    // Only the watchdog ends a wait that never completes
    do begin
      @(posedge mclk_in);
    end while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge mclk_in);
    check("wait release", avs_waitrequest_out, 32'h1);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, 4'hF);
  endtask
  task automatic rd(input string what, input logic [4:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0, 4'hF);
    check(what, q, exp);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Run is under a thousand cycles; far margin here
  initial begin
    #1000000;
    n_errors++;
    results();
  end
  initial begin
    repeat (5) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
    wr(`EEC_A_RELOAD, 32'h5);
    wr(`EEC_A_TRIG, 32'h1);
    rd("reload off", `EEC_A_RELOAD, 32'h0);
    rd("status off", `EEC_A_STATUS, 32'h0);
    wr(`EEC_A_CTRL, 32'h1);
    rd("ctrl", `EEC_A_CTRL, 32'h1);
    rd("status idle", `EEC_A_STATUS, 32'h0);
    wr(`EEC_A_PRESC, 32'h4321);
    rd("presc", `EEC_A_PRESC, 32'h4321);
    wr(`EEC_A_PRESC, 32'h1110);
    bus(`EEC_A_RELOAD, 1'b1, 32'hABCD, 4'h1);
    rd("lane", `EEC_A_RELOAD, 32'hCD);
    wr(5'h1C, 32'h1);
    rd("unmapped", 5'h1C, 32'h0);
    wr(`EEC_A_MODE, 32'h4);
    wr(`EEC_A_RELOAD, 32'h2);
    wr(`EEC_A_TRIG, 32'h1);
    rd("status run", `EEC_A_STATUS, 32'h1);
    check("active pin run", channel_active_status_out, 32'h1);
    rd("trig", `EEC_A_TRIG, 32'h0);
    rd("count start", `EEC_A_COUNT, 32'h2);
    src.toggle(2, 10);
    rd("count edge", `EEC_A_COUNT, 32'h1);
    wr(`EEC_A_RELOAD, 32'h4);
    src.toggle(4, 10);
    check("irq first", n_irq, 32'h1);
    rd("count reload", `EEC_A_COUNT, 32'h4);
    src.toggle(10, 10);
    check("irq period", n_irq, 32'h2);
    rd("count period", `EEC_A_COUNT, 32'h4);
    // Pin pulses while frozen and returns to its level, so no edge remains
    clk_en_in <= 1'b0;
    src.toggle(2, 10);
    clk_en_in <= 1'b1;
    rd("count frozen", `EEC_A_COUNT, 32'h4);
    check("irq frozen", n_irq, 32'h2);
    wr(`EEC_A_TRIG, 32'h2);
    // Two rises and two falls per mode; odd modes filtered
    for (int m = 0; m < 4; m++) begin
      e = (m == 3) ? 32'h9 : (m == 2) ? 32'h5 : 32'h7;
      wr(`EEC_A_MODE, 32'((m << 2) | ((m & 1) << 4) | m));
      wr(`EEC_A_RELOAD, 32'h9);
      wr(`EEC_A_TRIG, 32'h1);
      src.toggle(4, 12);
      rd("count mode", `EEC_A_COUNT, e);
      wr(`EEC_A_TRIG, 32'h2);
      rd("status stop", `EEC_A_STATUS, 32'h0);
      check("active pin stop", channel_active_status_out, 32'h0);
      src.toggle(2, 12);
      rd("count held", `EEC_A_COUNT, e);
    end
    check("irq none", n_irq, 32'h2);
    // Disable while running so the clear has something to undo
    wr(`EEC_A_TRIG, 32'h1);
    wr(`EEC_A_CTRL, 32'h0);
    rd("count clear", `EEC_A_COUNT, 32'h0);
    rd("mode clear", `EEC_A_MODE, 32'h0);
    rd("reload clear", `EEC_A_RELOAD, 32'h0);
    rd("status clear", `EEC_A_STATUS, 32'h0);
    check("active pin clear", channel_active_status_out, 32'h0);
    results();
  end
endmodule // tb
`default_nettype wire
